// File: hw/dac_cfg_ctrl.v
// Configuration control, data path and latch logic of the octal converter
// Function
// R1 - Readback gives input data when select is 0, converter data when 1.
// R2 - With correction on, input register keeps raw word, converter register corrected.
// R3 - Latch pin high and load bit set copies converter data into latches.
// R4 - Load refreshes only channels written since last latch pin low or load.
// R5 - Load bit clears itself once its latch update is done.
// R6 - Correction off: load bit updates latches immediately when set.
// R7 - Load bit writes are ignored while latch pin is low.
// R8 - Software reset bit resets the device like hardware reset, then reads 0. Code sets OFFSET_A_RELOAD to 1 and keeps RDATA and RVALID.
// R9 - Group A power-down puts channels 0 to 3 in power-down.
// R10 - Group B power-down puts channels 4 to 7 in power-down.
// R11 - Correction on: input word adjusted by channel gain and zero registers.
// R12 - Correction off: input word passes unchanged straight to converter register.
// R13 - Reserved bit 9 ignores writes and reads as 0.
// R14 - Span bit selects six times reference at 0, four times at 1.
// R15 - Span bit change reloads group A offset register with trimmed value.
// R16 - Zero registers are 16-bit two's complement, default zero.
// R17 - Gain registers are 16-bit straight binary, default 32768.
// R18 - Correction is input times gain over 32768 plus zero, saturated.
`include "dac_cfg_consts.vh"
`default_nettype none
module dac_cfg_ctrl #(
  parameter CHANNELS = 8,
  parameter [15:0] OFFA_TRIM_X6 = 16'h8000,
  parameter [15:0] OFFA_TRIM_X4 = 16'h8000
) (
  // Clock and reset
  input wire CLK,
  input wire NRST,
  // Register port from the serial front end
  input wire WR_STB,
  input wire RD_STB,
  input wire [1:0] SEL,
  input wire [2:0] CHAN,
  input wire [15:0] WDATA,
  output reg [15:0] RDATA,
  output reg RVALID,
  // Asynchronous latch load pin, active low
  input wire LATCH_LOAD_PIN_N,
  // Analog-side controls
  output reg [16*CHANNELS-1:0] LATCH_OUT,
  output reg GROUP_A_POWERDOWN,
  output reg GROUP_B_POWERDOWN,
  output reg SPAN_A_X4,
  output reg [15:0] OFFSET_A,
  output reg OFFSET_A_RELOAD
);

  // ****************************************
  // Functions
  // ****************************************

  // Corrected word; 33-bit product keeps full range before saturation
  function [15:0] correct;
    input [15:0] din;
    input [15:0] gain;
    input [15:0] zero;
    reg [32:0] prod;
    reg signed [18:0] sum;
    begin
      prod = {17'h00000, din} * {17'h00000, gain};
      sum = $signed({2'h0, prod[31:15]}) + $signed({{3{zero[15]}}, zero}); // see R18
      if (sum < 0) begin
        correct = 16'h0000;
      end else if (sum > 19'sh0FFFF) begin
        correct = 16'hFFFF;
      end else begin
        correct = sum[15:0];
      end
    end
  endfunction

  // ****************************************
  // Pin synchroniser
  // ****************************************

  reg ll_meta_reg;
  reg ll_sync_reg;
  reg ll_prev_reg;
  // Two stages plus an edge-detect stage; logic reads the second and the third
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ll_meta_reg <= 1'b1;
      ll_sync_reg <= 1'b1;
      ll_prev_reg <= 1'b1;
    end else begin
      ll_meta_reg <= LATCH_LOAD_PIN_N;
      ll_sync_reg <= ll_meta_reg;
      ll_prev_reg <= ll_sync_reg;
    end
  end
  wire pin_fall = ll_prev_reg & ~ll_sync_reg;

  // ****************************************
  // Register state
  // ****************************************

  reg [7:0] cfg_reg;
  reg sw_rst_reg;
  reg load_pend_reg;
  reg calc_busy_reg;
  reg [2:0] calc_chan_reg;
  reg [15:0] in_reg [0:CHANNELS-1];
  reg [15:0] dac_reg [0:CHANNELS-1];
  reg [15:0] zero_reg [0:CHANNELS-1];
  reg [15:0] gain_reg [0:CHANNELS-1];
  reg [CHANNELS-1:0] dirty_reg;
  integer i;

  wire cfg_wr = WR_STB & (SEL == `SEL_CFG);
  wire data_wr = WR_STB & (SEL == `SEL_DATA);
  wire cal_on = cfg_reg[`CFG_CALEN_BIT-8];
  // Load request accepted only with pin high; pin low ignores it
  wire ld_req = cfg_wr & WDATA[`CFG_SYNCLD_BIT] & ll_sync_reg; // see R7
  // Load waits until no correction is in flight
  wire do_load = (load_pend_reg | ld_req) & ~calc_busy_reg & ~(data_wr & cal_on); // see R3
  wire new_span = WDATA[`CFG_SPANA_BIT];

  // Main state; software reset reuses the power-on values except OFFSET_A_RELOAD, which it sets to 1
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_reg <= `CFG_RESET;
      sw_rst_reg <= 1'b0;
      load_pend_reg <= 1'b0;
      calc_busy_reg <= 1'b0;
      calc_chan_reg <= 3'h0;
      dirty_reg <= {CHANNELS{1'b0}};
      LATCH_OUT <= {16*CHANNELS{1'b0}};
      OFFSET_A <= OFFA_TRIM_X6;
      OFFSET_A_RELOAD <= 1'b0;
      for (i = 0; i < CHANNELS; i = i + 1) begin
        in_reg[i] <= 16'h0000;
        dac_reg[i] <= 16'h0000;
        zero_reg[i] <= `ZERO_RESET; // see R16
        gain_reg[i] <= `GAIN_RESET; // see R17
      end
    end else if (sw_rst_reg) begin
      // One-cycle internal reset; the bit then reads 0
      cfg_reg <= `CFG_RESET; // see R8
      sw_rst_reg <= 1'b0;
      load_pend_reg <= 1'b0;
      calc_busy_reg <= 1'b0;
      calc_chan_reg <= 3'h0;
      dirty_reg <= {CHANNELS{1'b0}};
      LATCH_OUT <= {16*CHANNELS{1'b0}};
      OFFSET_A <= OFFA_TRIM_X6;
      OFFSET_A_RELOAD <= 1'b1;
      for (i = 0; i < CHANNELS; i = i + 1) begin
        in_reg[i] <= 16'h0000;
        dac_reg[i] <= 16'h0000;
        zero_reg[i] <= `ZERO_RESET;
        gain_reg[i] <= `GAIN_RESET;
      end
    end else begin
      OFFSET_A_RELOAD <= 1'b0;
      // Configuration write; load and reset bits are actions, bit 9 dropped
      if (cfg_wr) begin
        cfg_reg <= {WDATA[15], 1'b0, 1'b0, WDATA[12:10], 1'b0, new_span}; // see R13
        sw_rst_reg <= WDATA[`CFG_SWRST_BIT]; // see R8
        if (new_span != cfg_reg[0]) begin
          OFFSET_A <= new_span ? OFFA_TRIM_X4 : OFFA_TRIM_X6; // see R15
          OFFSET_A_RELOAD <= 1'b1;
        end
      end
      // Correction register writes
      if (WR_STB & (SEL == `SEL_ZERO)) begin
        zero_reg[CHAN] <= WDATA;
      end
      if (WR_STB & (SEL == `SEL_GAIN)) begin
        gain_reg[CHAN] <= WDATA;
      end
      // Correction takes one extra cycle; without it data goes straight through
      calc_busy_reg <= data_wr & cal_on;
      if (calc_busy_reg) begin
        dac_reg[calc_chan_reg] <= correct(in_reg[calc_chan_reg], gain_reg[calc_chan_reg],
          zero_reg[calc_chan_reg]); // see R11
      end
      if (data_wr) begin
        in_reg[CHAN] <= WDATA; // see R2
        calc_chan_reg <= CHAN;
        if (!cal_on) begin
          dac_reg[CHAN] <= WDATA; // see R12
        end
      end
      // Latch transfer by pin fall or load bit; only written channels move
      if (pin_fall | do_load) begin
        for (i = 0; i < CHANNELS; i = i + 1) begin
          if (dirty_reg[i]) begin
            LATCH_OUT[16*i +: 16] <= dac_reg[i]; // see R4
          end
        end
        dirty_reg <= {CHANNELS{1'b0}};
        load_pend_reg <= 1'b0; // see R5
      end else begin
        load_pend_reg <= load_pend_reg | ld_req; // see R6
      end
      // Write after a transfer decision still marks its channel
      if (data_wr) begin
        dirty_reg[CHAN] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Outputs and readback
  // ****************************************

  // Group controls registered again from configuration flops, one cycle after them
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      GROUP_A_POWERDOWN <= 1'b0;
      GROUP_B_POWERDOWN <= 1'b0;
      SPAN_A_X4 <= 1'b0;
    end else begin
      GROUP_A_POWERDOWN <= cfg_reg[`CFG_PDA_BIT-8]; // see R9
      GROUP_B_POWERDOWN <= cfg_reg[`CFG_PDB_BIT-8]; // see R10
      SPAN_A_X4 <= cfg_reg[`CFG_SPANA_BIT-8]; // see R14
    end
  end

  // Read data registered one cycle after the strobe
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= 16'h0000;
      RVALID <= 1'b0;
    end else begin
      RVALID <= RD_STB;
      if (RD_STB) begin
        case (SEL)
          `SEL_CFG: RDATA <= {cfg_reg[7], load_pend_reg, sw_rst_reg, cfg_reg[4:0], 8'h00};
          `SEL_DATA: RDATA <= cfg_reg[7] ? dac_reg[CHAN] : in_reg[CHAN]; // see R1
          `SEL_ZERO: RDATA <= zero_reg[CHAN];
          `SEL_GAIN: RDATA <= gain_reg[CHAN];
          default: RDATA <= 16'h0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// File: hw/dac_cfg_consts.vh
// Constants for the converter configuration control block
`ifndef DAC_CFG_CONSTS_VH
`define DAC_CFG_CONSTS_VH
// Configuration register field positions
`define CFG_READSEL_BIT 15
`define CFG_SYNCLD_BIT 14
`define CFG_SWRST_BIT 13
`define CFG_PDA_BIT 12
`define CFG_PDB_BIT 11
`define CFG_CALEN_BIT 10
`define CFG_RSVD_BIT 9
`define CFG_SPANA_BIT 8
// Reset value of the upper configuration byte
`define CFG_RESET 8'h80
// Correction defaults
`define ZERO_RESET 16'h0000
`define GAIN_RESET 16'h8000
// Access kinds on the register port
`define SEL_CFG 2'h0
`define SEL_DATA 2'h1
`define SEL_ZERO 2'h2
`define SEL_GAIN 2'h3
`endif

// File: test/dac_cfg_asserts.sv
// Port checker for the configuration control block
`default_nettype none
module dac_cfg_asserts #(
  parameter [15:0] OFFA_TRIM_X6 = 16'h8000,
  parameter [15:0] OFFA_TRIM_X4 = 16'h8000
) (
  // Clock, reset and register port
  input wire logic CLK,
  input wire logic NRST,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [1:0] SEL,
  input wire logic [15:0] WDATA,
  input wire logic [15:0] RDATA,
  input wire logic RVALID,
  // Analog-side controls
  input wire logic GROUP_A_POWERDOWN,
  input wire logic GROUP_B_POWERDOWN,
  input wire logic SPAN_A_X4,
  input wire logic [15:0] OFFSET_A,
  input wire logic OFFSET_A_RELOAD
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // Soft reset wipes state a cycle late, so it is kept apart
  wire cfg_wr = WR_STB && SEL == 2'h0 && !WDATA[13];
  wire rst_wr = WR_STB && SEL == 2'h0 && WDATA[13];
  a_read_answer_pulse: assert property (RD_STB |=> RVALID)
    else $error("read strobe without answer");
  a_no_stray_answer: assert property (!RD_STB && !rst_wr |=> !RVALID)
    else $error("answer without read strobe");
  a_rdata_holds: assert property (!RD_STB && !$past(rst_wr) && !$past(rst_wr, 2) |=> $stable(RDATA))
    else $error("read data moved without a read");
  a_pd_follows_cfg: assert property (cfg_wr ##1 !WR_STB [*2] |=>
    {GROUP_A_POWERDOWN, GROUP_B_POWERDOWN} == $past(WDATA[12:11], 3)) else $error("power-down level wrong");
  // A config write on the very next edge would legally overtake this one
  a_span_follows_cfg: assert property (cfg_wr ##1 !(WR_STB && SEL == 2'h0) |=>
    ##1 SPAN_A_X4 == $past(WDATA[8], 3)) else $error("span select wrong");
  a_offset_reload: assert property ($changed(SPAN_A_X4) |-> ##[0:1]
    OFFSET_A == (SPAN_A_X4 ? OFFA_TRIM_X4 : OFFA_TRIM_X6)) else $error("offset not reloaded");
  a_reload_marks_offset: assert property ($changed(OFFSET_A) |-> OFFSET_A_RELOAD)
    else $error("offset moved without reload flag");
  a_soft_reset_wipes: assert property (rst_wr |-> ##3 !GROUP_A_POWERDOWN && !GROUP_B_POWERDOWN
    && !SPAN_A_X4 && OFFSET_A == OFFA_TRIM_X6) else $error("soft reset left state");
  a_reserved_reads_zero: assert property (RD_STB && SEL == 2'h0 |=>
    RDATA[9] == 1'b0 && RDATA[13] == 1'b0 && RDATA[7:0] == 8'h00) else $error("reserved config bits not 0");
endmodule
bind dac_cfg_ctrl dac_cfg_asserts #(.OFFA_TRIM_X6(OFFA_TRIM_X6), .OFFA_TRIM_X4(OFFA_TRIM_X4)) u_dac_cfg_asserts (
  .CLK, .NRST, .WR_STB, .RD_STB, .SEL, .WDATA, .RDATA, .RVALID, .GROUP_A_POWERDOWN, .GROUP_B_POWERDOWN,
  .SPAN_A_X4, .OFFSET_A, .OFFSET_A_RELOAD);
`default_nettype wire

// File: test/host.sv
// Host model driving the register port of the control block
`default_nettype none
module host (
  // Clock
  input wire logic clk,
  // Register port towards the device
  output var logic wr_stb = 1'b0,
  output var logic rd_stb = 1'b0,
  output var logic [1:0] sel = 2'h0,
  output var logic [2:0] chan = 3'h0,
  output var logic [15:0] wdata = 16'h0000,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  // Fields are scrambled on release so stale values never look valid
  task automatic wr(input logic [1:0] s, input logic [2:0] c, input logic [15:0] d);
    @(posedge clk) #1;
    {wr_stb, sel, chan, wdata} = {1'b1, s, c, d};
    @(posedge clk) #1;
    {wr_stb, sel, chan, wdata} = {1'b0, ~s, ~c, ~d};
  endtask
  // Answer is taken at the edge after the strobe
  task automatic rd(input logic [1:0] s, input logic [2:0] c, output logic [15:0] d);
    @(posedge clk) #1;
    {rd_stb, sel, chan} = {1'b1, s, c};
    @(posedge clk) #1;
    {rd_stb, sel, chan} = {1'b0, ~s, ~c};
    d = rvalid ? rdata : 16'hXXXX;
  endtask
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the configuration control block
`include "dac_cfg_consts.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, nrst = 1'b0, pin_n = 1'b1;
  logic wr_stb, rd_stb, rvalid, pda, pdb, span, reload;
  logic [1:0] sel;
  logic [2:0] chan, ch;
  logic [15:0] wdata, rdata, offa, q, v, g, z;
  logic [127:0] latch;
  logic [31:0] seed = 32'h931049E6;
  int err_total = 0, checks_done = 0;
  dac_cfg_ctrl #(.OFFA_TRIM_X6(16'h1234), .OFFA_TRIM_X4(16'h4321)) u_dac_cfg_ctrl (.CLK(clk), .NRST(nrst),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .SEL(sel), .CHAN(chan), .WDATA(wdata), .RDATA(rdata), .RVALID(rvalid),
    .LATCH_LOAD_PIN_N(pin_n), .LATCH_OUT(latch), .GROUP_A_POWERDOWN(pda), .GROUP_B_POWERDOWN(pdb),
    .SPAN_A_X4(span), .OFFSET_A(offa), .OFFSET_A_RELOAD(reload));
  host u_host (.clk(clk), .wr_stb(wr_stb), .rd_stb(rd_stb), .sel(sel), .chan(chan), .wdata(wdata),
    .rdata(rdata), .rvalid(rvalid));
  // Xorshift source, fixed start
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  // Gain scaled by 32768 plus signed zero, clamped
  function automatic logic [15:0] corr(input logic [15:0] d, input logic [15:0] gn, input logic [15:0] zr);
    longint t;
    t = ((longint'(d) * gn) >> 15) + longint'($signed(zr));
    return t < 0 ? 16'h0000 : t > 65535 ? 16'hFFFF : t[15:0];
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    forever #50 clk = ~clk;
  end
  // Watchdog well past the expected run
  initial begin
    #3000000;
    err_total++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 nrst = 1'b1;
    u_host.rd(`SEL_GAIN, 3'h7, q);
    chk("gain reset", `GAIN_RESET, q);
    u_host.rd(`SEL_ZERO, 3'h7, q);
    chk("zero reset", `ZERO_RESET, q);
    // Random config fields, load and reset bits masked off; z keeps the previous word
    z = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      v = i < 2 ? (i ? 16'h0000 : 16'h1BFF) : rnd() & 16'h9FFF;
      u_host.wr(`SEL_CFG, 3'h0, v);
      chk("offset reload", {15'h0, v[8] ^ z[8]}, {15'h0, reload});
      z = v;
      u_host.rd(`SEL_CFG, 3'h0, q);
      chk("cfg", v & 16'h9D00, q);
      chk("group pd span", {13'h0, v[12:11], v[8]}, {13'h0, pda, pdb, span});
      chk("offset a", v[8] ? 16'h4321 : 16'h1234, offa);
    end
    v = rnd();
    u_host.wr(`SEL_CFG, 3'h0, 16'h0000);
    u_host.wr(`SEL_DATA, 3'h2, v);
    u_host.wr(`SEL_DATA, 3'h5, ~v);
    u_host.rd(`SEL_DATA, 3'h2, q);
    chk("input reg", v, q);
    u_host.wr(`SEL_CFG, 3'h0, 16'h8000);
    u_host.rd(`SEL_DATA, 3'h5, q);
    chk("dac reg", ~v, q);
    chk("latch early", 16'h0000, latch[47:32]);
    u_host.wr(`SEL_CFG, 3'h0, 16'hC000);
    repeat (2) @(posedge clk);
    chk("latch ch2", v, latch[47:32]);
    chk("latch ch5", ~v, latch[95:80]);
    chk("latch ch0", 16'h0000, latch[15:0]);
    u_host.rd(`SEL_CFG, 3'h0, q);
    chk("load clear", 16'h8000, q);
    // Pin low loads, and the load bit is ignored meanwhile
    u_host.wr(`SEL_DATA, 3'h1, v);
    pin_n = 1'b0;
    repeat (5) @(posedge clk);
    chk("pin load", v, latch[31:16]);
    u_host.wr(`SEL_DATA, 3'h0, v);
    u_host.wr(`SEL_CFG, 3'h0, 16'hC000);
    repeat (3) @(posedge clk);
    chk("load ignored", 16'h0000, latch[15:0]);
    #1 pin_n = 1'b1;
    // Correction with saturating corners first
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      ch = v[2:0];
      g = i < 2 ? (i ? 16'h0000 : 16'hFFFF) : rnd();
      z = i < 2 ? (i ? 16'h8000 : 16'h7FFF) : rnd();
      u_host.wr(`SEL_CFG, 3'h0, 16'h0400);
      u_host.wr(`SEL_GAIN, ch, g);
      u_host.wr(`SEL_ZERO, ch, z);
      v = rnd();
      u_host.wr(`SEL_DATA, ch, v);
      u_host.rd(`SEL_DATA, ch, q);
      chk("raw word", v, q);
      u_host.wr(`SEL_CFG, 3'h0, 16'h8400);
      u_host.rd(`SEL_DATA, ch, q);
      chk("corrected", corr(v, g, z), q);
    end
    u_host.wr(`SEL_CFG, 3'h0, 16'hC400);
    repeat (2) @(posedge clk);
    chk("latch corr", corr(v, g, z), latch[ch*16 +: 16]);
    u_host.rd(`SEL_CFG, 3'h0, q);
    chk("load clear corr", 16'h8400, q);
    u_host.wr(`SEL_CFG, 3'h0, 16'h3900);
    repeat (3) @(posedge clk);
    u_host.rd(`SEL_CFG, 3'h0, q);
    chk("soft reset cfg", 16'h8000, q);
    chk("soft reset latch", 16'h0000, latch[ch*16 +: 16]);
    close_out();
  end
endmodule
`default_nettype wire
